// *** design/dcs_pkg.sv ***
package dcs_pkg;
    // Array geometry
    localparam int SETS = 128;
    localparam int WAYS = 8;
    localparam int STAT_W = 6;
    localparam int OUT_W = 4;
    // Wishbone register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    // Control register fields
    localparam int CTRL_SPD = 0;
    localparam int CTRL_SHEN = 1;
    localparam int CTRL_IXE = 2;
    localparam int CTRL_DXE = 3;
    localparam logic [3:0] CTRL_RST = 4'h2;
    // Status register fields
    localparam int STAT_BLK_LSB = 0;
    localparam int STAT_INIT = 8;
    localparam int STAT_OUT_LSB = 12;
    // Attribute code forced when translation is off: W=0 I=0 M=1 G=1
    localparam logic [3:0] ATTR_REAL = 4'h3;

    // Access attribute code
    typedef struct packed {
        logic w;
        logic i;
        logic m;
        logic g;
    } dcs_attr_t;

    // Per-block status bits
    typedef struct packed {
        logic c;
        logic d;
        logic m;
        logic r;
        logic s;
        logic v;
    } dcs_stat_t;

    // Block events from pipeline, reload path and snooper
    typedef enum logic [4:0] {
        EV_RLD_BIU_LD, EV_RLD_L2_LD, EV_RLD_ST, EV_ST_HIT, EV_LD_HIT,
        EV_REPLACE, EV_BLK_STFLUSH, EV_BLK_INVAL, EV_BLK_FLUSH, EV_BLK_ZERO,
        EV_BLK_ALLOC, EV_SNP_CLEAN, EV_SNP_READ, EV_SNP_INVAL, EV_BARRIER,
        EV_SYNC, EV_ICBI, EV_TLBIE, EV_TLBSYNC
    } dcs_kind_t;

    // Block event
    typedef struct packed {
        logic vld;
        dcs_kind_t kind;
        logic [6:0] idx;
        logic [2:0] way;
        logic hit;
        logic transient;
        logic shared_snoop_response;
        logic l2_r;
        logic l2_s;
        logic from_l2;
        dcs_attr_t attr;
    } dcs_evt_t;

    // Access attribute request
    typedef struct packed {
        logic vld;
        logic instr;
        logic instr_block_xlate_pair;
        dcs_attr_t attr;
    } dcs_acc_t;

    // Load or fetch issue request
    typedef struct packed {
        logic vld;
        logic guarded;
        logic certain;
        logic oldest;
    } dcs_ldq_t;

    // Snooped transaction
    typedef struct packed {
        logic vld;
        logic self;
        dcs_kind_t kind;
    } dcs_snp_t;

    // Outgoing coherency broadcast
    typedef struct packed {
        logic vld;
        logic global;
        dcs_kind_t kind;
    } dcs_bc_t;
endpackage : dcs_pkg

// *** design/dcs_stat_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
// Status bit array with one write and one registered read port
module dcs_stat_mem #(
    parameter int AW = 10,
    parameter int DW = 6
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);
    // Storage, no reset: the owner sweeps it clear
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Write port
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // Registered read
    always_ff @(posedge clk_i) begin
        rdata_o <= mem[raddr_i];
    end
endmodule : dcs_stat_mem
`default_nettype wire

// *** design/dcs_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcs_top #(
    parameter int SETS = dcs_pkg::SETS,
    parameter int WAYS = dcs_pkg::WAYS,
    parameter int OUT_W = dcs_pkg::OUT_W
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire dcs_pkg::dcs_evt_t EVT_I,
    output logic EVT_RDY_O,
    input wire dcs_pkg::dcs_acc_t ACC_I,
    output dcs_pkg::dcs_attr_t ACC_ATTR_O,
    output logic ACC_CACHE_O,
    output logic ACC_WT_O,
    output logic ACC_GLOBAL_O,
    input wire dcs_pkg::dcs_ldq_t LDQ_I,
    input wire logic LD_RET_I,
    output logic LD_GRANT_O,
    output logic LD_FILL_BLK_O,
    output logic LD_HOLD_O,
    input wire dcs_pkg::dcs_snp_t SNP_I,
    output logic ADDRESS_RETRY_O,
    output dcs_pkg::dcs_bc_t BCAST_O,
    output logic CASTOUT_O,
    output logic [9:0] CASTOUT_ADR_O
);
    localparam int NBLK = SETS * WAYS;
    initial begin
        if (SETS != 128 || WAYS != 8 || OUT_W < 2) begin
            $error("dcs_top: unsupported geometry or counter width");
        end
    end

    typedef enum {ST_INIT, ST_IDLE, ST_UPD} dcs_state_t;

    // Next block status for an event
    function automatic dcs_pkg::dcs_stat_t nxt_stat(
        input dcs_pkg::dcs_evt_t e, input dcs_pkg::dcs_stat_t cur,
        input logic shen);
        dcs_pkg::dcs_stat_t n;
        n = cur;
        case (e.kind)
            dcs_pkg::EV_RLD_BIU_LD: begin
                n = '0;
                n.v = 1'b1;
                n.c = ~e.transient;
                n.r = e.shared_snoop_response & shen;
                n.s = e.shared_snoop_response & shen;
            end
            dcs_pkg::EV_RLD_L2_LD: begin
                n = '0;
                n.v = 1'b1;
                n.r = e.l2_r & shen;
                n.s = (e.l2_r | e.l2_s) & shen;
            end
            dcs_pkg::EV_RLD_ST: begin
                n = '0;
                n.v = 1'b1;
                n.d = 1'b1;
                n.m = 1'b1;
                n.c = ~e.from_l2 & ~e.transient;
            end
            dcs_pkg::EV_ST_HIT: begin
                // Non-transient write-through hits leave status alone, so a 100x alias
                // and a 000x alias share one consistent block
                if (e.hit && !e.attr.w && !e.attr.i) begin
                    if (cur.s || cur.r) begin
                        n.v = 1'b0;
                    end else begin
                        n.d = 1'b1;
                        n.m = 1'b1;
                    end
                end
                if (e.hit && e.transient) begin
                    n.c = 1'b0;
                end
            end
            dcs_pkg::EV_LD_HIT: begin
                if (e.hit && e.transient) begin
                    n.c = 1'b0;
                end
            end
            dcs_pkg::EV_BLK_STFLUSH: begin
                if (e.hit) begin
                    n.d = 1'b0;
                    n.m = 1'b0;
                end
            end
            dcs_pkg::EV_BLK_INVAL, dcs_pkg::EV_BLK_FLUSH,
            dcs_pkg::EV_BLK_ZERO, dcs_pkg::EV_BLK_ALLOC,
            dcs_pkg::EV_SNP_INVAL: begin
                if (e.hit) begin
                    n.v = 1'b0;
                end
            end
            dcs_pkg::EV_SNP_CLEAN: begin
                if (e.hit) begin
                    n.m = 1'b0;
                end
            end
            dcs_pkg::EV_SNP_READ: begin
                if (e.hit) begin
                    n.m = 1'b0;
                    n.r = 1'b0;
                end
            end
            default: begin
                n = cur; // Shared is never cleared directly
            end
        endcase
        return n;
    endfunction : nxt_stat

    // Kinds that are broadcast on the bus
    function automatic logic is_bcast(input dcs_pkg::dcs_kind_t k);
        return k inside {dcs_pkg::EV_BLK_ZERO, dcs_pkg::EV_BLK_INVAL,
            dcs_pkg::EV_BLK_FLUSH, dcs_pkg::EV_BLK_STFLUSH,
            dcs_pkg::EV_BARRIER, dcs_pkg::EV_SYNC, dcs_pkg::EV_ICBI,
            dcs_pkg::EV_TLBIE, dcs_pkg::EV_TLBSYNC};
    endfunction : is_bcast

    // Registers and state
    dcs_state_t state_q, state_d;
    logic [9:0] init_q; // Sweep pointer for reset invalidate
    logic [3:0] ctrl_q; // Control register
    dcs_pkg::dcs_evt_t evt_q; // Event under update
    dcs_pkg::dcs_stat_t last_q; // Last written block status
    logic rdy_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [OUT_W-1:0] out_q; // Loads outstanding on the bus
    logic grant_q, fill_q, hold_q, address_retry_q, co_q;
    logic [9:0] co_adr_q;
    dcs_pkg::dcs_bc_t bc_q;
    dcs_pkg::dcs_attr_t attr_q;
    logic cache_q, wt_q, glob_q;

    // Memory wiring
    logic [5:0] rdata;
    dcs_pkg::dcs_stat_t cur_stat, new_stat;
    wire evt_take = EVT_I.vld & rdy_q & (state_q == ST_IDLE);
    wire [9:0] raddr = {EVT_I.idx, EVT_I.way};
    wire [9:0] evt_adr = {evt_q.idx, evt_q.way};
    wire upd_we = (state_q == ST_UPD) & ~evt_q.attr.i;
    wire mem_we = (state_q == ST_INIT) | upd_we;
    wire [9:0] waddr = (state_q == ST_INIT) ? init_q : evt_adr;
    assign cur_stat = dcs_pkg::dcs_stat_t'(rdata);
    assign new_stat = nxt_stat(evt_q, cur_stat, ctrl_q[dcs_pkg::CTRL_SHEN]);
    // Init sweep writes zero so every block starts invalid
    wire [5:0] wdata = (state_q == ST_INIT) ? 6'h00 : new_stat;

    dcs_stat_mem #(.AW(10), .DW(dcs_pkg::STAT_W)) u_mem (
        .clk_i(CLK_I),
        .we_i(mem_we),
        .waddr_i(waddr),
        .wdata_i(wdata),
        .raddr_i(raddr),
        .rdata_o(rdata)
    );

    // Engine next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_INIT: begin
                if (init_q == 10'(NBLK - 1)) begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (evt_take) begin
                    state_d = ST_UPD;
                end
            end
            ST_UPD: state_d = ST_IDLE;
            default: state_d = ST_INIT;
        endcase
    end

    // Engine registers
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            state_q <= ST_INIT;
            init_q <= 10'h000;
            rdy_q <= 1'b0;
            evt_q <= '0;
            last_q <= '0;
        end else begin
            state_q <= state_d;
            rdy_q <= (state_d == ST_IDLE);
            if (state_q == ST_INIT) begin
                init_q <= init_q + 10'h001;
            end
            if (evt_take) begin
                evt_q <= EVT_I;
            end
            if (upd_we) begin
                last_q <= new_stat;
            end
        end
    end

    // Victim castout and hardware broadcast of cache, barrier, sync and TLB ops
    wire co_hit = (state_q == ST_UPD) & (evt_q.kind == dcs_pkg::EV_REPLACE)
        & cur_stat.v & (cur_stat.c | cur_stat.d);
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            co_q <= 1'b0;
            co_adr_q <= 10'h000;
            bc_q <= '0;
        end else begin
            co_q <= co_hit;
            if (co_hit) begin
                co_adr_q <= evt_adr;
            end
            bc_q.vld <= evt_take & is_bcast(EVT_I.kind);
            bc_q.global <= EVT_I.attr.m;
            bc_q.kind <= EVT_I.kind;
        end
    end

    // Own TLBIE, TLBSYNC, ICBI or SYNC seen on the bus while engine busy is retried
    wire own_bc = SNP_I.vld & SNP_I.self & (SNP_I.kind inside
        {dcs_pkg::EV_TLBIE, dcs_pkg::EV_TLBSYNC, dcs_pkg::EV_ICBI,
         dcs_pkg::EV_SYNC});
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            address_retry_q <= 1'b0;
        end else begin
            address_retry_q <= own_bc & (state_q != ST_IDLE);
        end
    end

    // Attribute resolution for each access
    wire xl_on = ACC_I.instr ? ctrl_q[dcs_pkg::CTRL_IXE]
                             : ctrl_q[dcs_pkg::CTRL_DXE];
    dcs_pkg::dcs_attr_t eff_attr;
    always_comb begin
        eff_attr = ACC_I.attr;
        if (!xl_on) begin
            eff_attr = dcs_pkg::dcs_attr_t'(dcs_pkg::ATTR_REAL);
        end else if (ACC_I.instr && ACC_I.instr_block_xlate_pair) begin
            eff_attr.g = 1'b0;
        end
    end
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            attr_q <= '0;
            cache_q <= 1'b0;
            wt_q <= 1'b0;
            glob_q <= 1'b0;
        end else if (ACC_I.vld) begin
            attr_q <= eff_attr;
            cache_q <= ~eff_attr.i;
            wt_q <= eff_attr.w;
            glob_q <= eff_attr.m;
        end
    end

    // Issue gate for loads and fetches
    wire speculative_access_disable = ctrl_q[dcs_pkg::CTRL_SPD];
    wire out_full = (out_q == {OUT_W{1'b1}});
    wire bus_idle = (out_q == '0) & ~grant_q;
    wire g_ok = LDQ_I.certain & LDQ_I.oldest & bus_idle;
    wire u_ok = LDQ_I.certain | ~speculative_access_disable;
    wire ld_ok = LDQ_I.vld & ~out_full & (LDQ_I.guarded ? g_ok : u_ok);
    wire [OUT_W-1:0] out_d = out_q + OUT_W'(grant_q)
        - OUT_W'(LD_RET_I & (out_q != '0));
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            grant_q <= 1'b0;
            fill_q <= 1'b0;
            hold_q <= 1'b0;
            out_q <= '0;
        end else begin
            grant_q <= ld_ok;
            fill_q <= ld_ok & LDQ_I.guarded;
            hold_q <= LDQ_I.vld & ~ld_ok;
            out_q <= out_d;
        end
    end

    // Wishbone slave, one wait state per access
    wire wb_req = CYC_I & STB_I & ~ack_q;
    wire sel_ctrl = (ADR_I == dcs_pkg::REG_CTRL);
    wire sel_stat = (ADR_I == dcs_pkg::REG_STAT);
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_ctrl) begin
            rd_mux[3:0] = ctrl_q;
        end else if (sel_stat) begin
            rd_mux[dcs_pkg::STAT_BLK_LSB +: 6] = last_q;
            rd_mux[dcs_pkg::STAT_INIT] = (state_q == ST_INIT);
            rd_mux[dcs_pkg::STAT_OUT_LSB +: OUT_W] = out_q;
        end
    end
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
            ctrl_q <= dcs_pkg::CTRL_RST;
        end else begin
            ack_q <= wb_req;
            dat_q <= wb_req ? rd_mux : 32'h0000_0000;
            if (wb_req && WE_I && sel_ctrl && SEL_I[0]) begin
                ctrl_q <= DAT_I[3:0];
            end
        end
    end

    // Output wiring, all from flops
    assign DAT_O = dat_q;
    assign ACK_O = ack_q;
    assign EVT_RDY_O = rdy_q;
    assign ACC_ATTR_O = attr_q;
    assign ACC_CACHE_O = cache_q;
    assign ACC_WT_O = wt_q;
    assign ACC_GLOBAL_O = glob_q;
    assign LD_GRANT_O = grant_q;
    assign LD_FILL_BLK_O = fill_q;
    assign LD_HOLD_O = hold_q;
    assign ADDRESS_RETRY_O = address_retry_q;
    assign BCAST_O = bc_q;
    assign CASTOUT_O = co_q;
    assign CASTOUT_ADR_O = co_adr_q;

    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    a_real_mode: assert property (ACC_I.vld && !xl_on |=> attr_q == 4'h3)
        else $error("real mode code wrong");
    a_instr_block_xlate_pair_unguard: assert property (ACC_I.vld && xl_on && ACC_I.instr
        && ACC_I.instr_block_xlate_pair |=> !attr_q.g)
        else $error("instr_block_xlate_pair access guarded");
    a_global_m: assert property (ACC_I.vld |=> glob_q == $past(eff_attr.m)
        && cache_q == !$past(eff_attr.i))
        else $error("global or cache wrong");
    a_guard_spec: assert property (LDQ_I.vld && LDQ_I.guarded
        && !LDQ_I.certain |=> !grant_q && hold_q)
        else $error("speculative guarded load");
    a_guard_alone: assert property (grant_q && fill_q |-> out_q == '0)
        else $error("guarded load pipelined");
    a_spd_block: assert property (LDQ_I.vld && !LDQ_I.guarded
        && !LDQ_I.certain && speculative_access_disable |=> !grant_q)
        else $error("speculation not disabled");
    a_fill_cert: assert property (fill_q |-> $past(LDQ_I.certain))
        else $error("fill without certainty");
    a_bcast_op: assert property (evt_take && is_bcast(EVT_I.kind)
        |=> bc_q.vld && bc_q.kind == $past(EVT_I.kind))
        else $error("op not broadcast");
    a_self_retry: assert property (address_retry_q |-> $past(own_bc))
        else $error("retry without own broadcast");
    a_castout: assert property (co_hit |=> co_q ##1 !co_q)
        else $error("castout not pulsed");
    a_legal_stat: assert property (upd_we && new_stat.v |-> !(new_stat.r
        && !new_stat.s) && !(new_stat.m && (new_stat.s || new_stat.r)))
        else $error("illegal status combination");
    a_no_shared: assert property (upd_we && !ctrl_q[dcs_pkg::CTRL_SHEN]
        && evt_q.kind inside {dcs_pkg::EV_RLD_BIU_LD, dcs_pkg::EV_RLD_L2_LD}
        |-> !new_stat.s) else $error("shared in three-state");
    a_rld_valid: assert property (upd_we && evt_q.kind inside
        {dcs_pkg::EV_RLD_BIU_LD, dcs_pkg::EV_RLD_ST} |-> new_stat.v
        && new_stat.c == (!evt_q.transient && !(evt_q.from_l2
        && evt_q.kind == dcs_pkg::EV_RLD_ST)))
        else $error("reload status wrong");
    a_store_dirty: assert property (upd_we && evt_q.kind
        == dcs_pkg::EV_RLD_ST |-> new_stat.d && new_stat.m)
        else $error("store reload not dirty");
    a_snp_read: assert property (upd_we && evt_q.hit && evt_q.kind
        == dcs_pkg::EV_SNP_READ |-> !new_stat.r && !new_stat.m
        && new_stat.s == cur_stat.s) else $error("snoop read wrong");
    a_init_len: assert property ($fell(state_q == ST_INIT) |->
        $past(init_q) == 10'(NBLK - 1)) else $error("sweep short");
    a_wt_alias: assert property (upd_we && evt_q.kind == dcs_pkg::EV_ST_HIT
        && evt_q.attr.w && !evt_q.transient |-> new_stat == cur_stat)
        else $error("write-through changed status");
    c_castout: cover property (co_hit ##1 co_q);
    c_guard_grant: cover property (LDQ_I.vld && LDQ_I.guarded ##1 grant_q);
    c_retry: cover property (address_retry_q);
    c_shared_rld: cover property (upd_we && new_stat.s && new_stat.r);
endmodule : dcs_top
`default_nettype wire

// *** verif/dcs_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Memory side of the bus: returns granted loads one at a time
module dcs_bus_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic grant_i,
    output logic ret_o
);
    logic [3:0] pend_q; // Loads still waiting for data
    logic [3:0] wait_q; // Cycles until the next return
    logic [7:0] lfsr_q; // Varies the latency
    wire logic done = pend_q != 4'h0 && wait_q == 4'h0; // Return now
    // Count grants, answer each after four to seven cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_q <= 4'h0;
            wait_q <= 4'h4;
            lfsr_q <= 8'h5a;
            ret_o <= 1'b0;
        end else begin
            lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[3]};
            ret_o <= done;
            if (done || pend_q == 4'h0) begin
                wait_q <= {2'b01, lfsr_q[1:0]};
            end else begin
                wait_q <= wait_q - 4'h1;
            end
            pend_q <= pend_q + {3'h0, grant_i} - {3'h0, done};
        end
    end
endmodule : dcs_bus_model
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0; // Core clock
    logic rst = 1'b1; // Reset, active high
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ret, ar, co;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rd, q, r;
    logic ack, rdy, grant, fill, hold, address_retry, cout, cache, wt, glob, x;
    logic [9:0] cadr;
    logic [3:0] ex;
    dcs_pkg::dcs_evt_t evt = '0, e;
    dcs_pkg::dcs_acc_t acc = '0;
    dcs_pkg::dcs_ldq_t ldq = '0;
    dcs_pkg::dcs_snp_t snp = '0;
    dcs_pkg::dcs_attr_t aat;
    dcs_pkg::dcs_bc_t bc, bcs;
    dcs_pkg::dcs_stat_t cur = '0; // Expected status of the test block
    logic [31:0] seed = 32'h9ba8bafb;
    logic sh = 1'b1; // Shared enable as last written
    int err_count = 0, checks = 0, i;
    always #5 clk = ~clk;
    dcs_top dut (.CLK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .SEL_I(4'hf), .DAT_I(wd), .DAT_O(rd),
        .ACK_O(ack), .EVT_I(evt), .EVT_RDY_O(rdy), .ACC_I(acc),
        .ACC_ATTR_O(aat), .ACC_CACHE_O(cache), .ACC_WT_O(wt),
        .ACC_GLOBAL_O(glob), .LDQ_I(ldq), .LD_RET_I(ret),
        .LD_GRANT_O(grant), .LD_FILL_BLK_O(fill), .LD_HOLD_O(hold),
        .SNP_I(snp), .ADDRESS_RETRY_O(address_retry), .BCAST_O(bc), .CASTOUT_O(cout),
        .CASTOUT_ADR_O(cadr));
    dcs_bus_model bus (.clk_i(clk), .rst_i(rst), .grant_i(grant),
        .ret_o(ret));
    // Xorshift source for random stimulus
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Expected status after one block event
    function dcs_pkg::dcs_stat_t nxt(input dcs_pkg::dcs_evt_t v,
        input dcs_pkg::dcs_stat_t c, input logic s);
        dcs_pkg::dcs_stat_t n;
        n = c;
        case (v.kind)
            dcs_pkg::EV_RLD_BIU_LD: n = {~v.transient, 2'h0, {2{v.shared_snoop_response & s}},
                1'b1};
            dcs_pkg::EV_RLD_L2_LD: n = {3'h0, v.l2_r & s,
                (v.l2_r | v.l2_s) & s, 1'b1};
            dcs_pkg::EV_RLD_ST: n = {~v.from_l2 & ~v.transient, 2'b11,
                3'b001};
            dcs_pkg::EV_ST_HIT: if (!v.attr.w) begin
                if (c.r | c.s) n.v = 1'b0;
                else {n.d, n.m} = 2'b11;
            end
            dcs_pkg::EV_BLK_STFLUSH: {n.d, n.m} = 2'b00;
            dcs_pkg::EV_BLK_INVAL, dcs_pkg::EV_BLK_FLUSH, dcs_pkg::EV_BLK_ZERO,
            dcs_pkg::EV_BLK_ALLOC, dcs_pkg::EV_SNP_INVAL: n.v = 1'b0;
            dcs_pkg::EV_SNP_CLEAN: n.m = 1'b0;
            dcs_pkg::EV_SNP_READ: {n.m, n.r} = 2'b00;
            default: ;
        endcase
        if (v.transient && (v.kind == dcs_pkg::EV_LD_HIT ||
            v.kind == dcs_pkg::EV_ST_HIT)) n.c = 1'b0;
        return n;
    endfunction : nxt
    // Prints the counts and the verdict
    task wrap_up();
        $display("Counts: %0d checks, %0d mismatches", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    // Single comparison point
    task chk(input string n, input logic [31:0] s, input logic [31:0] v);
        checks++;
        if (s !== v) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, v, s);
        end
    endtask : chk
    // Ends the run when a wait used up its bound
    task bound(input int n, input int lim);
        if (n >= lim) begin
            err_count++;
            wrap_up();
        end
    endtask : bound
    // Classic Wishbone single cycle, read data lands in q
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
        for (n = 0; n < 50 && ack !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        bound(n, 50);
        q = rd;
        @(posedge clk);
        {cyc, stb} <= 2'b00;
    endtask : wb
    // One block event, with a snoop offered in the cycle after it
    task ev(input dcs_pkg::dcs_evt_t v, input dcs_pkg::dcs_snp_t s);
        int n;
        #1;
        for (n = 0; n < 2000 && rdy !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        bound(n, 2000);
        @(posedge clk);
        evt <= v;
        @(posedge clk);
        evt.vld <= 1'b0;
        snp <= s;
        #1;
        bcs = bc;
        @(posedge clk);
        snp.vld <= 1'b0;
        #1;
        {ar, co} = {address_retry, cout};
    endtask : ev
    // One load request; v is the expected grant, fill and hold
    task ld(input logic [2:0] f, input logic [2:0] v);
        @(posedge clk);
        ldq <= {1'b1, f};
        @(posedge clk);
        ldq.vld <= 1'b0;
        #1;
        chk("load", {grant, fill, hold}, v);
    endtask : ld
    // Waits until no load is outstanding
    task drain();
        int n;
        for (n = 0; n < 100; n++) begin
            wb(1'b0, dcs_pkg::REG_STAT, 32'h0);
            if (q[15:12] === 4'h0) break;
        end
        bound(n, 100);
    endtask : drain
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, dcs_pkg::REG_STAT, 32'h0);
        chk("sweep", q[dcs_pkg::STAT_INIT], 1'b1);
        wb(1'b0, dcs_pkg::REG_CTRL, 32'h0);
        chk("ctrl", q, {28'h0, dcs_pkg::CTRL_RST});
        wb(1'b0, 8'h08, 32'h0);
        chk("unmapped", q, 32'h0);
        // Random event chain on one block, fresh from reset
        for (i = 0; i < 80; i++) begin
            r = rnd();
            if (r[31:29] == 3'h0) begin
                sh = r[28];
                wb(1'b1, dcs_pkg::REG_CTRL, {30'h0, sh, 1'b0});
            end
            e = {1'b1, dcs_pkg::dcs_kind_t'(5'(r[3:0] % 14)), 7'h15, 3'h5,
                1'b1, r[8:4], r[9], 1'b0, r[10], 1'b0};
            ev(e, '0);
            chk("castout", co, e.kind == dcs_pkg::EV_REPLACE &&
                cur.v && (cur.c || cur.d));
            if (co === 1'b1) chk("victim", cadr, 10'h0ad);
            cur = nxt(e, cur, sh);
            wb(1'b0, dcs_pkg::REG_STAT, 32'h0);
            if (e.kind != dcs_pkg::EV_REPLACE) chk("status", q[5:0], cur);
        end
        // Broadcast operations, each snooped back by this device
        for (i = 14; i < 19; i++) begin
            r = rnd();
            e = {1'b1, 5'(i), 7'h7f, 3'h7, 1'b1, 5'h0, 2'b00, r[0], 1'b0};
            ev(e, {2'b11, 5'(i)});
            chk("bcast", bcs, {1'b1, r[0], 5'(i)});
            chk("retry", ar, i != 14);
        end
        // Access attributes under random translation settings
        for (i = 0; i < 24; i++) begin
            r = rnd();
            wb(1'b1, dcs_pkg::REG_CTRL, {28'h0, r[7:4]});
            x = r[8] ? r[6] : r[7];
            @(posedge clk);
            acc <= {1'b1, r[8], r[9] & x, r[3:0]};
            @(posedge clk);
            acc.vld <= 1'b0;
            #1;
            ex = x ? r[3:0] & {3'h7, ~(r[8] & r[9])} : dcs_pkg::ATTR_REAL;
            chk("attr", aat, ex);
            chk("use", {cache, wt, glob}, {~ex[2], ex[3], ex[1]});
        end
        // Load gating with speculation disabled
        wb(1'b1, dcs_pkg::REG_CTRL, 32'hf);
        ld(3'b000, 3'b001);
        ld(3'b010, 3'b100);
        ld(3'b111, 3'b001);
        drain();
        ld(3'b101, 3'b001);
        ld(3'b110, 3'b001);
        ld(3'b111, 3'b110);
        // Speculation allowed: random unguarded loads
        wb(1'b1, dcs_pkg::REG_CTRL, 32'he);
        for (i = 0; i < 8; i++) begin
            r = rnd();
            ld({1'b0, r[1:0]}, 3'b100);
        end
        drain();
        @(posedge clk);
        ldq <= 4'b1010;
        @(posedge clk);
        ldq <= 4'b1111;
        @(posedge clk);
        ldq.vld <= 1'b0;
        #1;
        chk("pipelined", {grant, fill, hold}, 3'b001);
        drain();
        wrap_up();
    end
endmodule : tb
`default_nettype wire
